// ---- pkg/mft_pkg.sv ----
/*
  shared constants and carrier types of the timer pin and interrupt layer.
  assumes a 40 mhz apb clock and two timer instances on one apb slot.
*/
package mft_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int MFT_INSTS = 2;
  localparam int MFT_PADS = 16;
  localparam int MFT_PSEL_W = 4;
  localparam int MFT_AW = 12;

  // ----------------------------------------------------------------
  // register map: instance n sits at n * 0x40, pad select is shared
  // ----------------------------------------------------------------
  localparam logic [5:0] MFT_OFF_MCTRL = 6'h18;
  localparam logic [5:0] MFT_OFF_ICTRL = 6'h1c;
  localparam logic [5:0] MFT_OFF_ICLR = 6'h20;
  localparam logic [5:0] MFT_OFF_IPEND = 6'h24;
  localparam int MFT_INST_BIT = 6;
  localparam logic [MFT_AW-1:0] MFT_OFF_PADSEL = 12'h080;
  localparam logic [8:0] MFT_MCTRL_RST = 9'h000;
  localparam logic [3:0] MFT_IEN_RST = 4'h0;
  localparam logic [15:0] MFT_PADSEL_RST = 16'h0000;

  // ----------------------------------------------------------------
  // mode field encoding
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MFT_M1 = 2'b00,
    MFT_M2 = 2'b01,
    MFT_M3 = 2'b10,
    MFT_M4 = 2'b11
  } mft_mode_t;

  // mode control word, msb first: bit 8 down to bit 0
  typedef struct packed {
    logic pulse_train_select;
    logic tmr_enable;
    logic output_level_bit;
    logic second_pin_enable;
    logic first_pin_enable;
    logic second_edge_polarity;
    logic first_edge_polarity;
    mft_mode_t mode_select_field;
  } mft_ctrl_t;

  // events reported by the counter logic, same clock
  typedef struct packed {
    logic uflow1;
    logic reload1_a;
    logic reload1_b;
    logic uflow2;
    logic reload2_b;
  } mft_cnt_ev_t;

  // one-cycle commands back to the counter logic, plus hold levels
  typedef struct packed {
    logic cap_a;
    logic cap_b;
    logic preset1;
    logic preset2;
    logic ext_event;
    logic hold1;
    logic hold2;
  } mft_strobe_t;

  typedef struct packed {
    mft_ctrl_t ctrl;
    logic [3:0] source_irq_enable;
    logic [3:0] source_pending_flag;
    logic armed1;
    logic armed2;
    logic prev_a;
    logic prev_b;
    mft_strobe_t str;
    logic irq1;
    logic irq2;
  } mft_inst_t;

endpackage : mft_pkg

// ---- rtl/mft_pins_irqs.sv ----
/*
  pin roles, capture pad selection, pending flags and interrupt lines of a
  dual multifunction timer, with an apb register slave.
  assumes counters and reload registers live in a neighbouring block on pclk,
  reporting underflow and reload events and obeying the strobes given here.
*/
`timescale 1ns/1ps

module mft_pins_irqs
  import mft_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [MFT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // counter side, per instance
  input wire mft_cnt_ev_t [MFT_INSTS-1:0] cnt_ev,
  output mft_ctrl_t [MFT_INSTS-1:0] ctrl_o,
  output mft_strobe_t [MFT_INSTS-1:0] strobe_o,
  // device pads
  input wire logic [MFT_PADS-1:0] pad_in,
  output logic pwm_pad_one,
  output logic pwm_pad_two,
  // interrupt controller
  output logic inst1_irq_line_one,
  output logic inst1_irq_line_two,
  output logic inst2_irq_line_one,
  output logic inst2_irq_line_two
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    mft_inst_t [MFT_INSTS-1:0] inst;
    logic [15:0] capture_pad_select;
    logic [MFT_PADS-1:0] sync1;
    logic [MFT_PADS-1:0] sync2;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } mft_state_t;

  mft_state_t st_q;
  mft_state_t st_d;

  // elaboration guard: every pad must be reachable by one select nibble
  if (MFT_PADS > (1 << MFT_PSEL_W)) begin : g_bad_pads
    $error("pad count exceeds select width");
  end

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  logic acc_w;
  logic in_inst;
  logic [MFT_INSTS-1:0] hit_ctrl;
  logic [MFT_INSTS-1:0] hit_ien;
  logic [MFT_INSTS-1:0] hit_clr;
  logic [MFT_INSTS-1:0] hit_pend;
  logic hit_psel;
  logic [MFT_INSTS-1:0] edge_a;
  logic [MFT_INSTS-1:0] edge_b;

  // writes land only on the access edge that also sees pready
  assign acc_w = psel && penable && st_q.ready && pwrite;
  assign in_inst = (paddr[MFT_AW-1:MFT_INST_BIT+1] == '0);
  assign hit_psel = (paddr == MFT_OFF_PADSEL);

  genvar gi;
  generate
    for (gi = 0; gi < MFT_INSTS; gi++) begin : g_inst
      logic sel_i;
      logic [MFT_PSEL_W-1:0] sa;
      logic [MFT_PSEL_W-1:0] sb;
      logic cur_a;
      logic cur_b;
      assign sel_i = in_inst && (paddr[MFT_INST_BIT] == 1'(gi));
      assign hit_ctrl[gi] = sel_i && (paddr[5:0] == MFT_OFF_MCTRL);
      assign hit_ien[gi] = sel_i && (paddr[5:0] == MFT_OFF_ICTRL);
      assign hit_clr[gi] = sel_i && (paddr[5:0] == MFT_OFF_ICLR);
      assign hit_pend[gi] = sel_i && (paddr[5:0] == MFT_OFF_IPEND);
      // each capture input picks its own synchronised pad
      assign sa = st_q.capture_pad_select[gi*8 +: MFT_PSEL_W];
      assign sb = st_q.capture_pad_select[gi*8+4 +: MFT_PSEL_W];
      assign cur_a = st_q.sync2[sa];
      assign cur_b = st_q.sync2[sb];
      // polarity bit: 1 rising, 0 falling
      assign edge_a[gi] = st_q.inst[gi].ctrl.first_edge_polarity ?
                          (cur_a && !st_q.inst[gi].prev_a) : (!cur_a && st_q.inst[gi].prev_a);
      assign edge_b[gi] = st_q.inst[gi].ctrl.second_edge_polarity ?
                          (cur_b && !st_q.inst[gi].prev_b) : (!cur_b && st_q.inst[gi].prev_b);
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    mft_inst_t n;
    mft_mode_t m;
    logic capa;
    logic capb;
    logic [3:0] setv;
    logic [3:0] clrv;
    n = '0;
    m = MFT_M1;
    capa = 1'b0;
    capb = 1'b0;
    setv = '0;
    clrv = '0;
    st_d = st_q;
    // two flops per pad; only sync2 feeds any logic
    st_d.sync1 = pad_in;
    st_d.sync2 = st_q.sync1;
    for (int i = 0; i < MFT_INSTS; i++) begin
      n = st_q.inst[i];
      m = n.ctrl.mode_select_field;
      n.prev_a = g_cur_a(i);
      n.prev_b = g_cur_b(i);
      // capture roles depend on mode
      capa = n.ctrl.tmr_enable && edge_a[i] && (m == MFT_M2);
      capb = n.ctrl.tmr_enable && edge_b[i] && (m == MFT_M2 || m == MFT_M4);
      n.str.cap_a = capa;
      n.str.cap_b = capb;
      // preset only while the pin's enable is set
      n.str.preset1 = (capa && n.ctrl.first_pin_enable) ||
                      (capb && (m == MFT_M2) && n.ctrl.second_pin_enable);
      n.str.preset2 = capb && (m == MFT_M4) && n.ctrl.second_pin_enable;
      // event input in mode 3, and in mode 1 unless pulse train
      n.str.ext_event = n.ctrl.tmr_enable && edge_b[i] &&
                        ((m == MFT_M1 && !n.ctrl.pulse_train_select) || m == MFT_M3);
      // counting waits for the first capture; disabling re-arms
      n.armed1 = n.ctrl.tmr_enable && (n.armed1 || capa || capb);
      n.armed2 = n.ctrl.tmr_enable && (n.armed2 || capb);
      n.str.hold1 = (m == MFT_M2) && !n.armed1;
      n.str.hold2 = (m == MFT_M4) && !n.armed2;
      // toggle keeps the level bit equal to the pin
      if (n.ctrl.first_pin_enable && cnt_ev[i].uflow1 && m != MFT_M2) begin
        n.ctrl.output_level_bit = !n.ctrl.output_level_bit;
      end
      // source events per mode
      setv[0] = (m != MFT_M2 && cnt_ev[i].reload1_a) || capa;
      setv[1] = (m == MFT_M1 && cnt_ev[i].reload1_b) || capb;
      setv[2] = (m == MFT_M2) && cnt_ev[i].uflow1;
      setv[3] = (m == MFT_M3) ? cnt_ev[i].reload2_b : cnt_ev[i].uflow2;
      clrv = '0;
      if (acc_w && hit_clr[i]) begin
        clrv = pwdata[3:0];
      end
      // sticky, and a set in the clear cycle wins
      n.source_pending_flag = (n.source_pending_flag & ~clrv) | setv;
      // software write of the level bit overrides a same-cycle toggle
      if (acc_w && hit_ctrl[i]) begin
        n.ctrl = pwdata[8:0];
      end
      if (acc_w && hit_ien[i]) begin
        n.source_irq_enable = pwdata[3:0];
      end
      // a, b, c share line one; d alone on line two
      n.irq1 = |(st_q.inst[i].source_pending_flag[2:0] & st_q.inst[i].source_irq_enable[2:0]);
      n.irq2 = st_q.inst[i].source_pending_flag[3] && st_q.inst[i].source_irq_enable[3];
      st_d.inst[i] = n;
    end
    if (acc_w && hit_psel) begin
      st_d.capture_pad_select = pwdata[15:0];
    end
    // read data prepared in setup so that pready can come from a flop
    st_d.ready = psel && !penable;
    st_d.slverr = 1'b0;
    st_d.rdata = '0;
    if (psel && !penable) begin
      st_d.slverr = 1'b1;
      if (hit_psel) begin
        st_d.rdata = {16'h0000, st_q.capture_pad_select};
        st_d.slverr = 1'b0;
      end
      for (int i = 0; i < MFT_INSTS; i++) begin
        if (hit_ctrl[i]) begin
          st_d.rdata = {23'h000000, st_q.inst[i].ctrl};
          st_d.slverr = 1'b0;
        end
        if (hit_ien[i]) begin
          st_d.rdata = {28'h0000000, st_q.inst[i].source_irq_enable};
          st_d.slverr = 1'b0;
        end
        if (hit_pend[i]) begin
          st_d.rdata = {28'h0000000, st_q.inst[i].source_pending_flag};
          st_d.slverr = 1'b0;
        end
        if (hit_clr[i]) begin
          st_d.slverr = 1'b0;
        end
      end
    end
  end

  // current selected pad levels, reused to remember the last sample
  function automatic logic g_cur_a(input int i);
    g_cur_a = st_q.sync2[st_q.capture_pad_select[i*8 +: MFT_PSEL_W]];
  endfunction : g_cur_a

  function automatic logic g_cur_b(input int i);
    g_cur_b = st_q.sync2[st_q.capture_pad_select[i*8+4 +: MFT_PSEL_W]];
  endfunction : g_cur_b

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      for (int i = 0; i < MFT_INSTS; i++) begin
        st_q.inst[i].ctrl <= MFT_MCTRL_RST;
        st_q.inst[i].source_irq_enable <= MFT_IEN_RST;
      end
      st_q.capture_pad_select <= MFT_PADSEL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from st_q
  // ----------------------------------------------------------------
  assign prdata = st_q.rdata;
  assign pready = st_q.ready;
  assign pslverr = st_q.slverr;
  assign pwm_pad_one = st_q.inst[0].ctrl.output_level_bit;
  assign pwm_pad_two = st_q.inst[1].ctrl.output_level_bit;
  assign inst1_irq_line_one = st_q.inst[0].irq1;
  assign inst1_irq_line_two = st_q.inst[0].irq2;
  assign inst2_irq_line_one = st_q.inst[1].irq1;
  assign inst2_irq_line_two = st_q.inst[1].irq2;

  generate
    for (gi = 0; gi < MFT_INSTS; gi++) begin : g_out
      assign ctrl_o[gi] = st_q.inst[gi].ctrl;
      assign strobe_o[gi] = st_q.inst[gi].str;
    end
  endgenerate

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  generate
    for (gi = 0; gi < MFT_INSTS; gi++) begin : g_chk
      logic wr_c;
      logic clr_any;
      assign wr_c = acc_w && hit_ctrl[gi];
      assign clr_any = acc_w && hit_clr[gi];

      chk_pin_toggle: assert property (
        (st_q.inst[gi].ctrl.first_pin_enable && cnt_ev[gi].uflow1 && !wr_c &&
         st_q.inst[gi].ctrl.mode_select_field != MFT_M2)
        |=> (ctrl_o[gi].output_level_bit != $past(ctrl_o[gi].output_level_bit)))
        else $error("first pin did not toggle on underflow");

      chk_pin_quiet: assert property (
        (!st_q.inst[gi].ctrl.first_pin_enable && !wr_c) |=> $stable(ctrl_o[gi].output_level_bit))
        else $error("first pin moved while disabled");

      chk_line_one: assert property (
        (st_q.inst[gi].source_pending_flag[1] && st_q.inst[gi].source_irq_enable[1])
        |=> st_q.inst[gi].irq1)
        else $error("source b did not raise line one");

      chk_line_two: assert property (
        (!st_q.inst[gi].source_irq_enable[3]) [*2] |-> !st_q.inst[gi].irq2)
        else $error("line two raised with source d disabled");

      chk_pend_sticky: assert property (
        (st_q.inst[gi].source_pending_flag[0] && !clr_any) |=> st_q.inst[gi].source_pending_flag[0])
        else $error("pending flag a dropped without clear");

      chk_src_d_set: assert property (
        (st_q.inst[gi].ctrl.mode_select_field == MFT_M3 && cnt_ev[gi].reload2_b)
        |=> st_q.inst[gi].source_pending_flag[3])
        else $error("source d missed reload in mode 3");

      chk_src_c_mode: assert property (
        (st_q.inst[gi].ctrl.mode_select_field != MFT_M2 && !st_q.inst[gi].source_pending_flag[2])
        |=> !st_q.inst[gi].source_pending_flag[2])
        else $error("source c set outside mode 2");

      chk_cap_preset: assert property (
        (edge_b[gi] && st_q.inst[gi].ctrl.tmr_enable && st_q.inst[gi].ctrl.second_pin_enable &&
         st_q.inst[gi].ctrl.mode_select_field == MFT_M4)
        |=> (strobe_o[gi].cap_b && strobe_o[gi].preset2) ##1 !strobe_o[gi].preset2 || edge_b[gi])
        else $error("mode 4 capture and preset not pulsed");

      chk_hold_run: assert property (
        (st_q.inst[gi].ctrl.mode_select_field == MFT_M2 && !st_q.inst[gi].armed1 && !edge_a[gi] &&
         !edge_b[gi] && !wr_c) |=> strobe_o[gi].hold1)
        else $error("counter one not held before capture");

      chk_hold_two: assert property (
        (st_q.inst[gi].ctrl.mode_select_field == MFT_M4 && !st_q.inst[gi].armed2 && !edge_b[gi] && !wr_c)
        |=> strobe_o[gi].hold2)
        else $error("counter two not held before capture");

      chk_strobe_off: assert property (
        !st_q.inst[gi].ctrl.tmr_enable
        |=> !(strobe_o[gi].cap_a || strobe_o[gi].cap_b || strobe_o[gi].ext_event))
        else $error("capture or event strobe with timer disabled");

      chk_src_b_mode3: assert property (
        (st_q.inst[gi].ctrl.mode_select_field == MFT_M3 && !st_q.inst[gi].source_pending_flag[1])
        |=> !st_q.inst[gi].source_pending_flag[1])
        else $error("source b set in mode 3");

      chk_irq_gate: assert property (
        (st_q.inst[gi].source_irq_enable[2:0] == 3'h0) |=> !st_q.inst[gi].irq1)
        else $error("line one raised with sources a to c disabled");
    end
  endgenerate

endmodule : mft_pins_irqs

// ---- dv/mft_pad_model.sv ----
/*
  pad side partner of the timer pin layer: drives the device pad levels.
  assumes the bench calls set_pad from its own process, once per pad change.
*/
`timescale 1ns/1ps
module mft_pad_model
  import mft_pkg::*;
(
  // clock
  input wire logic pclk,
  // pad levels toward the timer
  output logic [MFT_PADS-1:0] pad_in
);
  // pads idle low; each chosen pad is taken as already in its alternate function
  initial begin
    pad_in = '0;
  end

  // a pad moves just after a rising edge and holds for at least one clock
  task set_pad(input int p, input logic v);
    @(posedge pclk);
    pad_in[p] <= v;
  endtask : set_pad
endmodule : mft_pad_model

// ---- dv/multifunction_timer_pins_and_irqs_bench.sv ----
/*
  self-checking bench: apb register tasks, counter event pulses, pad edges.
  assumes the pad model and counter event pulses are the only stimulus besides apb.
*/
`timescale 1ns/1ps
module multifunction_timer_pins_and_irqs_bench;
  import mft_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [MFT_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  mft_cnt_ev_t [MFT_INSTS-1:0] cnt_ev;
  mft_ctrl_t [MFT_INSTS-1:0] ctrl_o;
  mft_strobe_t [MFT_INSTS-1:0] strobe_o;
  logic [MFT_PADS-1:0] pad_in;
  logic pwm_pad_one, pwm_pad_two, i1a, i1b, i2a, i2b;
  int bad_count, checked;
  // pending expected per mode, one nibble per event, uflow1 first
  logic [19:0] tab [4] = '{20'h01280, 20'h40080, 20'h01008, 20'h01080};

  mft_pins_irqs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cnt_ev(cnt_ev),
    .ctrl_o(ctrl_o), .strobe_o(strobe_o), .pad_in(pad_in), .pwm_pad_one(pwm_pad_one),
    .pwm_pad_two(pwm_pad_two), .inst1_irq_line_one(i1a), .inst1_irq_line_two(i1b),
    .inst2_irq_line_one(i2a), .inst2_irq_line_two(i2b));
  mft_pad_model u_pads (.pclk(pclk), .pad_in(pad_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task stop_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : stop_test

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge pclk);
      n++;
    end
    if (n == 16) begin
      bad_count++;
      $display("Error pready expected 1 seen 0");
      stop_test();
    end
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask : rd

  // one-cycle counter event of instance one, then let flags settle
  task ev(input int e);
    @(posedge pclk);
    cnt_ev[0] <= 5'h10 >> e;
    @(posedge pclk);
    cnt_ev[0] <= 5'h00;
    repeat (3) @(posedge pclk);
  endtask : ev

  // pad change, then gather the strobe pulses over the synchroniser latency
  task cap(input int p, input logic v, input logic [4:0] exp);
    logic [4:0] acc;
    acc = 5'h00;
    u_pads.set_pad(p, v);
    repeat (8) begin
      @(posedge pclk);
      acc = acc | strobe_o[0][6:2];
    end
    chk("strobes", {27'h0, exp}, {27'h0, acc});
  endtask : cap

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cnt_ev = '0;
    bad_count = 0;
    checked = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd("mctrl", 12'h018, 32'h0);
    rd("ictrl", 12'h01c, 32'h0);
    rd("ipend", 12'h024, 32'h0);
    rd("padsel", 12'h080, 32'h0);
    rd("unmapped", 12'h030, 32'h0);
    chk("slverr", 32'h1, {31'h0, err});
    $display("test registers done");
    // level is written before the clock enable so the output starts high
    apb(1'b1, 12'h018, 32'h040);
    apb(1'b1, 12'h018, 32'h0c0);
    @(posedge pclk);
    chk("pwm_one", 32'h1, {31'h0, pwm_pad_one});
    ev(0);
    chk("pwm_one", 32'h1, {31'h0, pwm_pad_one});
    apb(1'b1, 12'h018, 32'h0d0);
    ev(0);
    chk("pwm_one", 32'h0, {31'h0, pwm_pad_one});
    rd("mctrl", 12'h018, 32'h090);
    apb(1'b1, 12'h018, 32'h091);
    ev(0);
    chk("pwm_one", 32'h0, {31'h0, pwm_pad_one});
    apb(1'b1, 12'h058, 32'h040);
    @(posedge pclk);
    chk("pwm_two", 32'h1, {31'h0, pwm_pad_two});
    $display("test pwm done");
    apb(1'b1, 12'h01c, 32'hf);
    apb(1'b1, 12'h020, 32'hf);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 12'h018, 32'(m));
      for (int e = 0; e < 5; e++) begin
        ev(e);
        rd("ipend", 12'h024, {28'h0, tab[m][19-4*e -: 4]});
        chk("irq_one", {31'h0, |tab[m][18-4*e -: 3]}, {31'h0, i1a});
        chk("irq_two", {31'h0, tab[m][19-4*e]}, {31'h0, i1b});
        apb(1'b1, 12'h020, 32'hf);
      end
    end
    apb(1'b1, 12'h01c, 32'h0);
    ev(1);
    rd("ipend", 12'h024, 32'h1);
    chk("irq_one", 32'h0, {31'h0, i1a});
    apb(1'b1, 12'h01c, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq_one", 32'h1, {31'h0, i1a});
    apb(1'b1, 12'h020, 32'hf);
    // instance two: reload a and underflow two reach its own lines only
    apb(1'b1, 12'h05c, 32'hf);
    @(posedge pclk);
    cnt_ev[1] <= 5'h0a;
    @(posedge pclk);
    cnt_ev[1] <= 5'h00;
    repeat (3) @(posedge pclk);
    rd("ipend2", 12'h064, 32'h9);
    chk("irq2_one", 32'h1, {31'h0, i2a});
    chk("irq2_two", 32'h1, {31'h0, i2b});
    chk("irq_one", 32'h0, {31'h0, i1a});
    chk("irq_two", 32'h0, {31'h0, i1b});
    apb(1'b1, 12'h060, 32'hf);
    repeat (2) @(posedge pclk);
    chk("irq2_two", 32'h0, {31'h0, i2b});
    $display("test interrupts done");
    u_pads.set_pad(5, 1'b1);
    apb(1'b1, 12'h080, 32'h0053);
    apb(1'b1, 12'h018, 32'h0a5);
    // hold follows the registered mode, one cycle after the write lands
    repeat (2) @(posedge pclk);
    chk("hold1", 32'h1, {31'h0, strobe_o[0].hold1});
    cap(4, 1'b1, 5'h00);
    cap(3, 1'b1, 5'h10);
    chk("hold1", 32'h0, {31'h0, strobe_o[0].hold1});
    cap(3, 1'b0, 5'h00);
    cap(5, 1'b0, 5'h0c);
    rd("ipend", 12'h024, 32'h3);
    apb(1'b1, 12'h020, 32'hf);
    apb(1'b1, 12'h018, 32'h0ab);
    cap(5, 1'b1, 5'h0a);
    rd("ipend", 12'h024, 32'h2);
    apb(1'b1, 12'h018, 32'h088);
    cap(5, 1'b0, 5'h00);
    cap(5, 1'b1, 5'h01);
    apb(1'b1, 12'h018, 32'h188);
    cap(5, 1'b0, 5'h00);
    cap(5, 1'b1, 5'h00);
    chk("ctrl", 32'h188, {23'h0, ctrl_o[0]});
    apb(1'b1, 12'h018, 32'h08a);
    cap(5, 1'b0, 5'h00);
    cap(5, 1'b1, 5'h01);
    // timer enable clear refuses every capture and event
    apb(1'b1, 12'h018, 32'h00a);
    cap(5, 1'b0, 5'h00);
    cap(5, 1'b1, 5'h00);
    $display("test capture done");
    stop_test();
  end
endmodule : multifunction_timer_pins_and_irqs_bench
